//--- design/sio_params.svh
// Offsets, field masks, reset values and bus figures for the six-bit I/O port block.
// Assumes inclusion by bare name from design files; holds definitions only.
`ifndef SIO_PARAMS_SVH
`define SIO_PARAMS_SVH

// Register indices; the APB byte address is four times the index
`define SIO_IDX_B_LATCH      16'h0002
`define SIO_IDX_A_READBACK   16'h000E
`define SIO_IDX_B_READBACK   16'h000F
`define SIO_IDX_B_DIRECTION  16'h0F1C
`define SIO_IDX_A_PULLUP     16'h0F28
`define SIO_IDX_B_PULLUP     16'h0F29
`define SIO_IDX_B_FUNCTION   16'h0F36
`define SIO_IDX_B_OUT_TYPE   16'h0F43

// Implemented bit positions of each register
`define SIO_MASK_A_BITS      8'h0F
`define SIO_MASK_B_BITS      8'h3F
`define SIO_MASK_B_OD_BITS   8'h27

// Reset values
`define SIO_RST_BYTE         8'h00
`define SIO_RST_WORD         32'h0000_0000

// Bus geometry
`define SIO_APB_ADDR_W       16
`define SIO_APB_DATA_W       32
`define SIO_APB_MIN_ADDR_W   14

`endif

//--- design/sio_pkg.sv
// Types shared by the six-bit I/O port block.
// Assumes nothing of its surroundings.
package sio_pkg;
	typedef logic [7:0]  sio_byte_t;
	typedef logic [31:0] sio_word_t;
	typedef logic [15:0] sio_addr_t;
endpackage : sio_pkg

//--- design/sio_sync2.sv
// Two-flop synchroniser bank for pin levels.
// Assumes the inputs are asynchronous to clk and that srst is synchronous.
`timescale 1ns/1ps
`default_nettype none
module sio_sync2 #(
	parameter int WIDTH = 6
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("sio_sync2: WIDTH must be at least one");
		end
	endgenerate

	// The first stage is read by the second stage only
	always_ff @(posedge clk) begin
		if (srst) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule : sio_sync2 // sio_sync2
`default_nettype wire

//--- design/sio_pin_cell.sv
// Drive, pull-up and readback logic for one pin of the six-bit port.
// Assumes all control inputs come from registers on clk and pin_sync is synchronised.
`timescale 1ns/1ps
`default_nettype none
module sio_pin_cell #(
	parameter bit HAS_OUT_TYPE = 1'b1
) (
	input  wire logic direction,
	input  wire logic function_sel,
	input  wire logic open_drain,
	input  wire logic latch,
	input  wire logic periph_out,
	input  wire logic periph_oe,
	input  wire logic pullup_en,
	input  wire logic pin_sync,
	output logic      pin_out,
	output logic      pin_oe,
	output logic      pullup_on,
	output logic      readback
);
	logic od_sel;
	logic drive_req;
	logic data;

	// Pins without an output type bit are always push-pull
	assign od_sel = HAS_OUT_TYPE ? open_drain : 1'b0;

	// Bidirectional peripherals steer their own enable; the port function drives whenever the bit is an output
	assign data      = function_sel ? periph_out : latch;
	assign drive_req = direction & (function_sel ? periph_oe : 1'b1);

	// Open drain sinks only: the high side stays off and a one releases the pin
	assign pin_out   = od_sel ? 1'b0 : data;
	assign pin_oe    = od_sel ? (drive_req & ~data) : drive_req;

	assign pullup_on = pullup_en & (~direction | od_sel);

	// Push-pull outputs read zero where an output type bit exists; inputs, open drain and pins without one read the pin
	assign readback  = HAS_OUT_TYPE ? (pin_sync & (~direction | od_sel)) : pin_sync;
endmodule : sio_pin_cell // sio_pin_cell
`default_nettype wire

//--- design/sio_port.sv
// Six-bit I/O port with readback, plus pull-up and readback of the four-bit port.
// Assumes an APB master on clk, pins that are asynchronous to clk, and
// on-chip serial peripherals that run on clk and present output and enable per pin.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sio_params.svh"

// Summary of operation
// - Four-bit readback returns pin level for inputs, zero for outputs.
// - Six-bit port has per-bit direction; 1 is output, resets to input.
// - Output type on bits 0,1,2,5: 0 push-pull, 1 sink-only open drain.
// - Function select 0 gives latch drive; 1 routes the peripheral signal.
// - Pull-up connects only for inputs or open drain outputs; enables reset 0.
// - Six-bit readback: bits 3,4 always pin; others pin only if input/open drain.
// - Readback on bits 0,1,2,5: input gives pin, push-pull output zero, open drain output pin.
module sio_port #(
	parameter int PORT_A_WIDTH = 4,
	parameter int PORT_B_WIDTH = 6
) (
	input  wire logic                    clk,
	input  wire logic                    srst,
	// APB slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire sio_pkg::sio_addr_t      paddr,
	input  wire sio_pkg::sio_word_t      pwdata,
	input  wire logic [3:0]              pstrb,
	output sio_pkg::sio_word_t           prdata,
	output logic                         pready,
	output logic                         pslverr,
	// Four-bit port: direction comes from its own control logic
	input  wire logic [PORT_A_WIDTH-1:0] port_a_direction_bit,
	input  wire logic [PORT_A_WIDTH-1:0] port_a_pin_in,
	output logic      [PORT_A_WIDTH-1:0] port_a_pullup_on,
	// Six-bit port pins
	input  wire logic [PORT_B_WIDTH-1:0] port_b_pin_in,
	output logic      [PORT_B_WIDTH-1:0] port_b_pin_out,
	output logic      [PORT_B_WIDTH-1:0] port_b_pin_oe,
	output logic      [PORT_B_WIDTH-1:0] port_b_pullup_on,
	// Shared peripherals: synchronous serial, serial bus, UART and debug
	input  wire logic [PORT_B_WIDTH-1:0] periph_out,
	input  wire logic [PORT_B_WIDTH-1:0] periph_oe,
	output logic      [PORT_B_WIDTH-1:0] periph_in
);
	import sio_pkg::*;

	generate
		if (PORT_A_WIDTH != 4) begin : g_bad_a
			$error("sio_port: PORT_A_WIDTH must be 4");
		end
		if (PORT_B_WIDTH != 6) begin : g_bad_b
			$error("sio_port: PORT_B_WIDTH must be 6");
		end
		if ($bits(sio_addr_t) < `SIO_APB_MIN_ADDR_W) begin : g_bad_addr
			$error("sio_port: address too narrow for the register map");
		end
		// The masks must not claim positions beyond the pins
		if ((`SIO_MASK_A_BITS >> PORT_A_WIDTH) != 0) begin : g_bad_mask_a
			$error("sio_port: port a mask reaches past PORT_A_WIDTH");
		end
		if ((`SIO_MASK_B_BITS >> PORT_B_WIDTH) != 0) begin : g_bad_mask_b
			$error("sio_port: port b mask reaches past PORT_B_WIDTH");
		end
		if ((`SIO_MASK_B_OD_BITS & ~`SIO_MASK_B_BITS) != 8'h00) begin : g_bad_mask_od
			$error("sio_port: output type bits outside the port");
		end
	endgenerate

	// Byte addresses derived from the register indices
	localparam sio_addr_t ADDR_B_LATCH     = sio_addr_t'(`SIO_IDX_B_LATCH     << 2);
	localparam sio_addr_t ADDR_A_READBACK  = sio_addr_t'(`SIO_IDX_A_READBACK  << 2);
	localparam sio_addr_t ADDR_B_READBACK  = sio_addr_t'(`SIO_IDX_B_READBACK  << 2);
	localparam sio_addr_t ADDR_B_DIRECTION = sio_addr_t'(`SIO_IDX_B_DIRECTION << 2);
	localparam sio_addr_t ADDR_A_PULLUP    = sio_addr_t'(`SIO_IDX_A_PULLUP    << 2);
	localparam sio_addr_t ADDR_B_PULLUP    = sio_addr_t'(`SIO_IDX_B_PULLUP    << 2);
	localparam sio_addr_t ADDR_B_FUNCTION  = sio_addr_t'(`SIO_IDX_B_FUNCTION  << 2);
	localparam sio_addr_t ADDR_B_OUT_TYPE  = sio_addr_t'(`SIO_IDX_B_OUT_TYPE  << 2);

	localparam sio_byte_t MASK_A  = `SIO_MASK_A_BITS;
	localparam sio_byte_t MASK_B  = `SIO_MASK_B_BITS;
	localparam sio_byte_t MASK_OD = `SIO_MASK_B_OD_BITS;

	// Software-visible registers
	sio_byte_t port_b_output_latch_reg;
	sio_byte_t port_b_direction_reg;
	sio_byte_t port_b_function_select_reg;
	sio_byte_t port_b_output_type_reg;
	sio_byte_t port_a_pullup_enable_reg;
	sio_byte_t port_b_pullup_enable_reg;
	sio_word_t prdata_reg;

	// Bus decode
	logic      setup_phase;
	logic      write_commit;
	logic      addr_hit;
	logic      lane0_wr;
	sio_byte_t wr_byte;
	sio_byte_t rd_byte;
	logic      access_phase;

	// One strobe per writable register keeps every update block to its own concern
	logic      wr_b_latch;
	logic      wr_b_direction;
	logic      wr_b_function;
	logic      wr_b_out_type;
	logic      wr_a_pullup;
	logic      wr_b_pullup;

	// Write data already cut to the implemented positions of each register
	sio_byte_t wr_data_a;
	sio_byte_t wr_data_b;
	sio_byte_t wr_data_od;

	// Synchronised pin levels and derived readback
	logic [PORT_A_WIDTH-1:0] port_a_pin_sync;
	logic [PORT_B_WIDTH-1:0] port_b_pin_sync;
	sio_byte_t               port_a_pin_readback;
	sio_byte_t               port_b_pin_readback;
	logic [PORT_B_WIDTH-1:0] port_b_rb_bits;

	// Pins cross into clk before anything looks at them
	sio_sync2 #(
		.WIDTH (PORT_A_WIDTH)
	) u_sync_a (
		.clk      (clk),
		.srst     (srst),
		.async_in (port_a_pin_in),
		.sync_out (port_a_pin_sync)
	);

	sio_sync2 #(
		.WIDTH (PORT_B_WIDTH)
	) u_sync_b (
		.clk      (clk),
		.srst     (srst),
		.async_in (port_b_pin_in),
		.sync_out (port_b_pin_sync)
	);

	// Peripheral receivers see the synchronised pin whatever the port mode
	assign periph_in = port_b_pin_sync;

	// Zero-wait slave: every access phase completes at its first edge
	assign setup_phase  = psel & ~penable;
	assign access_phase = psel & penable;
	assign pready       = 1'b1;
	assign lane0_wr     = pstrb[0];
	assign wr_byte      = pwdata[7:0];
	assign write_commit = access_phase & pwrite & addr_hit & lane0_wr;

	always_comb begin
		case (paddr)
			ADDR_B_LATCH,
			ADDR_A_READBACK,
			ADDR_B_READBACK,
			ADDR_B_DIRECTION,
			ADDR_A_PULLUP,
			ADDR_B_PULLUP,
			ADDR_B_FUNCTION,
			ADDR_B_OUT_TYPE: addr_hit = 1'b1;
			default:         addr_hit = 1'b0;
		endcase
	end

	// Unmapped addresses answer with an error; the access still ends in one cycle
	assign pslverr = access_phase & ~addr_hit;

	// Readback registers get no strobe: a write to them ends normally and changes nothing
	assign wr_b_latch     = write_commit & (paddr == ADDR_B_LATCH);
	assign wr_b_direction = write_commit & (paddr == ADDR_B_DIRECTION);
	assign wr_b_function  = write_commit & (paddr == ADDR_B_FUNCTION);
	assign wr_b_out_type  = write_commit & (paddr == ADDR_B_OUT_TYPE);
	assign wr_a_pullup    = write_commit & (paddr == ADDR_A_PULLUP);
	assign wr_b_pullup    = write_commit & (paddr == ADDR_B_PULLUP);

	// Cutting at the write keeps absent positions at zero whatever software sends
	assign wr_data_a  = wr_byte & MASK_A;
	assign wr_data_b  = wr_byte & MASK_B;
	assign wr_data_od = wr_byte & MASK_OD;

	// Latch: data waits here until the bit is switched to output
	always_ff @(posedge clk) begin
		if (srst) begin
			port_b_output_latch_reg <= `SIO_RST_BYTE;
		end else if (wr_b_latch) begin
			port_b_output_latch_reg <= wr_data_b;
		end
	end

	// Direction resets to input so nothing is driven until software asks for it
	always_ff @(posedge clk) begin
		if (srst) begin
			port_b_direction_reg <= `SIO_RST_BYTE;
		end else if (wr_b_direction) begin
			port_b_direction_reg <= wr_data_b;
		end
	end

	// Selecting a peripheral alone never drives a pin; direction must be output too
	always_ff @(posedge clk) begin
		if (srst) begin
			port_b_function_select_reg <= `SIO_RST_BYTE;
		end else if (wr_b_function) begin
			port_b_function_select_reg <= wr_data_b;
		end
	end

	// Bits 3 and 4 have no output type choice, so they stay zero
	always_ff @(posedge clk) begin
		if (srst) begin
			port_b_output_type_reg <= `SIO_RST_BYTE;
		end else if (wr_b_out_type) begin
			port_b_output_type_reg <= wr_data_od;
		end
	end

	// Enables keep the written bits they implement (port b only 0,1,2,5); the pin logic decides when a pull-up really connects
	always_ff @(posedge clk) begin
		if (srst) begin
			port_a_pullup_enable_reg <= `SIO_RST_BYTE;
		end else if (wr_a_pullup) begin
			port_a_pullup_enable_reg <= wr_data_a;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			port_b_pullup_enable_reg <= `SIO_RST_BYTE;
		end else if (wr_b_pullup) begin
			port_b_pullup_enable_reg <= wr_data_od;
		end
	end

	// Four-bit port: readback and pull-up depend on direction alone
	always_comb begin
		port_a_pin_readback = `SIO_RST_BYTE;
		port_a_pin_readback[PORT_A_WIDTH-1:0] = port_a_pin_sync & ~port_a_direction_bit;
	end

	// No open drain on this port, so only inputs may take the pull-up
	assign port_a_pullup_on = port_a_pullup_enable_reg[PORT_A_WIDTH-1:0] & ~port_a_direction_bit;

	// One cell per pin; only bits 0,1,2,5 carry an output type bit
	genvar gi;
	generate
		for (gi = 0; gi < PORT_B_WIDTH; gi++) begin : g_pin
			localparam bit HAS_OD = MASK_OD[gi];
			sio_pin_cell #(
				.HAS_OUT_TYPE (HAS_OD)
			) u_cell (
				.direction    (port_b_direction_reg[gi]),
				.function_sel (port_b_function_select_reg[gi]),
				.open_drain   (port_b_output_type_reg[gi]),
				.latch        (port_b_output_latch_reg[gi]),
				.periph_out   (periph_out[gi]),
				.periph_oe    (periph_oe[gi]),
				.pullup_en    (port_b_pullup_enable_reg[gi]),
				.pin_sync     (port_b_pin_sync[gi]),
				.pin_out      (port_b_pin_out[gi]),
				.pin_oe       (port_b_pin_oe[gi]),
				.pullup_on    (port_b_pullup_on[gi]),
				.readback     (port_b_rb_bits[gi])
			);
		end
	endgenerate

	always_comb begin
		port_b_pin_readback = `SIO_RST_BYTE;
		port_b_pin_readback[PORT_B_WIDTH-1:0] = port_b_rb_bits;
	end

	// Read mux; upper bits of every register read as zero
	always_comb begin
		case (paddr)
			ADDR_B_LATCH:     rd_byte = port_b_output_latch_reg;
			ADDR_A_READBACK:  rd_byte = port_a_pin_readback;
			ADDR_B_READBACK:  rd_byte = port_b_pin_readback;
			ADDR_B_DIRECTION: rd_byte = port_b_direction_reg;
			ADDR_A_PULLUP:    rd_byte = port_a_pullup_enable_reg;
			ADDR_B_PULLUP:    rd_byte = port_b_pullup_enable_reg;
			ADDR_B_FUNCTION:  rd_byte = port_b_function_select_reg;
			ADDR_B_OUT_TYPE:  rd_byte = port_b_output_type_reg;
			default:          rd_byte = `SIO_RST_BYTE;
		endcase
	end

	// Read data is captured in the setup cycle so that prdata leaves a flip-flop;
	// the pin sample is therefore one cycle older than the access phase
	always_ff @(posedge clk) begin
		if (srst) begin
			prdata_reg <= `SIO_RST_WORD;
		end else if (setup_phase) begin
			prdata_reg <= {24'h00_0000, rd_byte};
		end
	end

	assign prdata = prdata_reg;

endmodule : sio_port // sio_port
`default_nettype wire

//--- verification/sio_port_sva.sv
// Concurrent checks on the APB and pin ports of sio_port.
// Assumes it is bound into sio_port and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
`include "sio_params.svh"
module sio_port_sva #(
	parameter int PORT_A_WIDTH = 4,
	parameter int PORT_B_WIDTH = 6
) (
	input wire logic                    clk,
	input wire logic                    srst,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire sio_pkg::sio_addr_t      paddr,
	input wire sio_pkg::sio_word_t      prdata,
	input wire logic                    pslverr,
	input wire logic [PORT_A_WIDTH-1:0] port_a_direction_bit,
	input wire logic [PORT_A_WIDTH-1:0] port_a_pullup_on,
	input wire logic [PORT_B_WIDTH-1:0] port_b_pin_out,
	input wire logic [PORT_B_WIDTH-1:0] port_b_pin_oe,
	input wire logic [PORT_B_WIDTH-1:0] port_b_pullup_on
);
	import sio_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	logic mapped;
	// The slave decodes the full byte address, so a misaligned address is unmapped
	assign mapped = (paddr[1:0] == 2'b00) && ({2'b00, paddr[15:2]} inside {`SIO_IDX_B_LATCH, `SIO_IDX_A_READBACK,
		`SIO_IDX_B_READBACK, `SIO_IDX_B_DIRECTION, `SIO_IDX_A_PULLUP, `SIO_IDX_B_PULLUP, `SIO_IDX_B_FUNCTION,
		`SIO_IDX_B_OUT_TYPE});
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_read;
		psel && penable && !pwrite;
	endsequence
	a_err_only_access: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside an access phase");
	a_err_unmapped: assert property (psel && penable && paddr[1:0] == 2'b00 && !mapped |-> pslverr)
		else $error("no error on unmapped address");
	a_no_err_mapped: assert property (psel && penable && mapped |-> !pslverr)
		else $error("error on mapped address");
	a_read_upper: assert property (s_setup ##1 s_read |-> prdata[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");
	a_unmapped_zero: assert property (s_setup ##1 (s_read and !mapped) |-> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_pull_b_drive: assert property ((port_b_pullup_on & port_b_pin_oe & port_b_pin_out) == 6'h00)
		else $error("pull-up on while pin driven high");
	a_pull_a_dir: assert property ((port_a_pullup_on & port_a_direction_bit) == 4'h0)
		else $error("port a pull-up on an output");
	a_pull_rsvd: assert property (port_b_pullup_on[4:3] == 2'b00)
		else $error("pull-up on a bit without enable");
	a_reset_idle: assert property ($fell(srst) |-> (port_b_pin_oe == 6'h00 && port_b_pullup_on == 6'h00) [*3])
		else $error("pins not idle after reset");
endmodule // sio_port_sva
`default_nettype wire

//--- verification/sio_pin_model.sv
// Board side of the six-bit port: external driver, pull-ups and a floating line.
// Assumes drive, enable and pull-up come straight from sio_port.
`timescale 1ns/1ps
`default_nettype none
module sio_pin_model #(
	parameter int W = 6
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] pin_out,
	input  wire logic [W-1:0] pin_oe,
	input  wire logic [W-1:0] pullup_on,
	input  wire logic [W-1:0] ext_en,
	input  wire logic [W-1:0] ext_val,
	output logic      [W-1:0] pin_level
);
	logic [W-1:0] float_reg = '0;
	// A line nobody holds wanders, so no reader may rely on it
	always_ff @(posedge clk) float_reg <= ~float_reg;
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (pin_oe[i]) pin_level[i] = pin_out[i];
			else if (ext_en[i]) pin_level[i] = ext_val[i];
			else if (pullup_on[i]) pin_level[i] = 1'b1;
			else pin_level[i] = float_reg[i];
		end
	end
endmodule // sio_pin_model
`default_nettype wire

//--- verification/tb.sv
// Self-checking bench for sio_port: registers over APB, pin drive, pull-ups and readback.
// Assumes the pin model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "sio_params.svh"
module tb;
	import sio_pkg::*;
	localparam logic [15:0] IDX [6] = '{`SIO_IDX_B_LATCH, `SIO_IDX_B_DIRECTION, `SIO_IDX_A_PULLUP,
		`SIO_IDX_B_PULLUP, `SIO_IDX_B_FUNCTION, `SIO_IDX_B_OUT_TYPE};
	localparam sio_byte_t MSK [6] = '{8'h3F, 8'h3F, 8'h0F, 8'h27, 8'h3F, 8'h27};
	logic       clk, srst, psel, penable, pwrite, pready, pslverr, samp;
	sio_addr_t  paddr;
	sio_word_t  pwdata, prdata;
	logic [3:0] pstrb, a_dir, a_pin, a_pu;
	logic [5:0] b_in, b_out, b_oe, b_pu, p_out, p_oe, p_in, ext, ee;
	sio_word_t  q[$];
	int         n_fail, compares;
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	sio_port dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.port_a_direction_bit(a_dir), .port_a_pin_in(a_pin), .port_a_pullup_on(a_pu),
		.port_b_pin_in(b_in), .port_b_pin_out(b_out), .port_b_pin_oe(b_oe), .port_b_pullup_on(b_pu),
		.periph_out(p_out), .periph_oe(p_oe), .periph_in(p_in));
	sio_pin_model pins (.clk(clk), .pin_out(b_out), .pin_oe(b_oe), .pullup_on(b_pu), .ext_en(ee),
		.ext_val(ext), .pin_level(b_in));
	task automatic check(string nm, sio_word_t exp, sio_word_t got);
		compares++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", nm, exp, got);
			n_fail++;
		end
	endtask
	task automatic print_verdict();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite) check("prdata", q.pop_front(), prdata);
		if (samp) check("pins", q.pop_front(), {4'h0, a_pu, p_in, b_pu, b_oe, b_out});
	end
	task automatic apb(logic wr, logic [15:0] idx, sio_byte_t d, logic [3:0] st);
		int n;
		@(posedge clk);
		psel <= 1;
		pwrite <= wr;
		paddr <= {idx[13:0], 2'b00};
		pwdata <= ($urandom & 32'hFFFF_FF00) | {24'h0, d};
		pstrb <= st;
		@(posedge clk);
		penable <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (pready) break;
		end
		if (n == 50) begin
			n_fail++;
			print_verdict();
		end
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rd(logic [15:0] idx, sio_byte_t e);
		q.push_back({24'h0, e});
		apb(0, idx, 8'h00, 4'hF);
	endtask
	initial begin
		logic [5:0] dir, fc, od, l, pu, en, dat, oe, out, lvl, pon, ev;
		sio_byte_t v;
		{psel, penable, pwrite, paddr, pwdata, pstrb, samp, a_dir, a_pin, p_out, p_oe, ext, ee} = '0;
		srst = 1;
		n_fail = 0;
		compares = 0;
		void'($urandom(39));
		repeat (12) @(posedge clk);
		srst <= 0;
		for (int j = 0; j < 6; j++) rd(IDX[j], 8'h00);
		rd(16'h0010, 8'h00);
		for (int j = 0; j < 6; j++) begin
			v = 8'($urandom);
			apb(1, IDX[j], v, 4'hF);
			rd(IDX[j], v & MSK[j]);
		end
		apb(1, IDX[0], 8'h15, 4'hF);
		// Lane 0 strobe low must leave the latch alone
		apb(1, IDX[0], 8'h2A, 4'hE);
		rd(IDX[0], 8'h15);
		for (int i = 0; i < 16; i++) begin
			{dir, fc, od, l, pu} = 30'($urandom);
			if (i == 0) dir = 6'h00;
			if (i == 1) {dir, fc} = 12'hFC0;
			v = 8'($urandom);
			od = od & 6'h27;
			a_pin <= v[7:4];
			{p_out, p_oe, ext, a_dir} <= 22'($urandom);
			apb(1, IDX[0], {2'b00, l}, 4'hF);
			apb(1, IDX[1], {2'b00, dir}, 4'hF);
			apb(1, IDX[2], v, 4'hF);
			apb(1, IDX[3], {2'b00, pu}, 4'hF);
			// Serial-interface selection lives outside this block
			apb(1, IDX[4], {2'b00, fc}, 4'hF);
			apb(1, IDX[5], {2'b00, od}, 4'hF);
			en = dir & (~fc | p_oe);
			dat = (fc & p_out) | (~fc & l);
			out = dat & ~od;
			oe = en & ~(od & dat);
			pon = pu & 6'h27 & (~dir | od);
			// Lines that neither the port drives nor a pull-up holds get the external driver
			ev = 6'($urandom) | ~(oe | pon);
			ee <= ev;
			lvl = (oe & out) | (~oe & ev & ext) | (~oe & ~ev);
			repeat (4) @(posedge clk);
			q.push_back({4'h0, v[3:0] & ~a_dir, lvl, pon, oe, out});
			samp <= 1;
			@(posedge clk);
			samp <= 0;
			rd(`SIO_IDX_B_READBACK, {2'b00, lvl & (6'h18 | ~dir | od)});
			rd(`SIO_IDX_A_READBACK, {4'h0, a_pin & ~a_dir});
		end
		print_verdict();
	end
endmodule // tb
bind sio_port sio_port_sva #(.PORT_A_WIDTH(PORT_A_WIDTH), .PORT_B_WIDTH(PORT_B_WIDTH)) u_sva (.clk(clk),
	.srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pslverr(pslverr), .port_a_direction_bit(port_a_direction_bit), .port_a_pullup_on(port_a_pullup_on),
	.port_b_pin_out(port_b_pin_out), .port_b_pin_oe(port_b_pin_oe), .port_b_pullup_on(port_b_pullup_on));
`default_nettype wire
